// >>> stop_ctrl_defines.svh
// Register map, field positions and reset values of the stop-mode controller
`ifndef STOP_CTRL_DEFINES_SVH
`define STOP_CTRL_DEFINES_SVH

// Register offsets
`define ADDR_CTRL        4'h0
`define ADDR_CLK         4'h1
`define ADDR_STAT        4'h2

// Control register fields
`define CTRL_STOP_EN     0
`define CTRL_DBG_EN      1
`define CTRL_VD_EN       2
`define CTRL_VD_STOP_EN  3
`define CTRL_PPD         4
`define CTRL_RTC_DEEP    5
`define CTRL_LVR_EN      6
`define CTRL_HIGH_TRIP   7
`define CTRL_RESET       8'h44

// Clock source register fields
`define CLK_IRC_EN       0
`define CLK_IRC_STOP     1
`define CLK_ERC_EN       2
`define CLK_ERC_STOP     3
`define CLK_HIGH_RANGE   4
`define CLK_ADC_ASYNC    5
`define CLK_COMPARATOR_BG 6
`define CLK_RESET        8'h00

// Status register fields
`define STAT_FLAG        0
`define STAT_ACK         1
`define STAT_MODE_LO     2
`define STAT_LATCH       4

`endif

// >>> stop_ctrl_pkg.sv
// Types shared by the stop-mode controller and its users
package stop_ctrl_pkg;

    typedef enum logic [1:0] {MODE_RUN, MODE_LIGHT, MODE_DEEP} stop_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef struct packed {
        logic rtc;
        logic low_voltage_detector;
        logic analog_comparator;
        logic adc;
        logic sci;
        logic pin;
    } wake_src_t;

    typedef struct packed {
        logic bus_clk;
        logic cpu_clk;
        logic periph_clk;
        logic debug_clk;
        logic irc_keep;
        logic external_oscillator_keep;
    } clk_gate_t;

    typedef struct packed {
        logic regulator_full;
        logic adc_run;
        logic analog_comparator_run;
        logic core_off;
        logic state_retain;
        logic io_latched;
        logic lvr_en;
        logic high_trip;
    } power_t;

endpackage

// >>> stop_mode_controller.sv
// Stop-mode entry, clock and power gating, wake and deep-stop recovery
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "stop_ctrl_defines.svh"

module stop_mode_controller
    import stop_ctrl_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire bus_req_t   bus,
    output logic [7:0]      rdata,
    input  wire logic       stop_req,
    input  wire logic       reset_pin_n,
    input  wire wake_src_t  wake_in,
    input  wire logic       dbg_mem_cmd,
    input  wire logic       dbg_bg_cmd,
    input  wire logic [7:0] periph_pin_en,
    output logic [7:0]      pin_by_port,
    output clk_gate_t       clk_gate,
    output power_t          power,
    output logic            illegal_reset,
    output logic            reset_fetch,
    output logic            irq_fetch,
    output logic            por_reset,
    output logic            enter_background,
    output logic            dbg_mem_grant,
    output logic            dbg_stop_err
);

    stop_mode_t state;
    logic [7:0] ctrl;
    logic [7:0] clk_cfg;
    logic [7:0] cap_ctrl;
    logic [7:0] cap_clk;
    logic       recovery_flag;
    logic       io_latch;
    logic       pin_meta;
    logic       pin_sync_n;
    wake_src_t  wake_meta;
    wake_src_t  wake_sync;
    logic       in_light;
    logic       in_deep;
    logic       bg_wake;
    logic       light_irq;
    logic       light_wake;
    logic       deep_wake;
    logic       ack_write;

    // Mode picked from the control bits at the moment STOP completes
    function automatic stop_mode_t select_mode(input logic [7:0] c);
        stop_mode_t m;
        m = MODE_LIGHT;
        if (c[`CTRL_DBG_EN] || c[`CTRL_VD_STOP_EN]) begin
            m = MODE_LIGHT;
        end else if (c[`CTRL_PPD]) begin
            m = MODE_DEEP;
        end
        return m;
    endfunction

    // True when this access is a write to the given register
    function automatic logic reg_write(input bus_req_t b, input logic [3:0] a);
        return b.wr && (b.addr == a);
    endfunction

    // Two-flop synchronisers for pin and asynchronous wake sources
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_meta   <= 1'h1;
            pin_sync_n <= 1'h1;
            wake_meta  <= '0;
            wake_sync  <= '0;
        end else begin
            pin_meta   <= reset_pin_n;
            pin_sync_n <= pin_meta;
            wake_meta  <= wake_in;
            wake_sync  <= wake_meta;
        end
    end

    assign in_light = (state == MODE_LIGHT);
    assign in_deep  = (state == MODE_DEEP);

    assign bg_wake = in_light && dbg_bg_cmd && cap_ctrl[`CTRL_DBG_EN];

    assign light_irq  = in_light && (|wake_sync);
    assign light_wake = in_light && (!pin_sync_n || light_irq || bg_wake);

    // deep stop: pin, or counter when enabled
    assign deep_wake = in_deep && (!pin_sync_n ||
                       (wake_sync.rtc && cap_ctrl[`CTRL_RTC_DEEP]));

    assign ack_write = reg_write(bus, `ADDR_STAT) && bus.wdata[`STAT_ACK];

    // Mode sequencer; code 3 is illegal and falls back to run
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= MODE_RUN;
        end else begin
            unique case (state)
                MODE_RUN: begin
                    if (stop_req && ctrl[`CTRL_STOP_EN]) begin
                        state <= select_mode(ctrl);
                    end
                end
                MODE_LIGHT: begin
                    if (light_wake) begin
                        state <= MODE_RUN;
                    end
                end
                MODE_DEEP: begin
                    if (deep_wake) begin
                        state <= MODE_RUN;
                    end
                end
                default: begin
                    state <= MODE_RUN;
                end
            endcase
        end
    end

    // settings frozen for the stop period
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cap_ctrl <= `CTRL_RESET;
            cap_clk  <= `CLK_RESET;
        end else if (state == MODE_RUN && stop_req && ctrl[`CTRL_STOP_EN]) begin
            cap_ctrl <= ctrl;
            cap_clk  <= clk_cfg;
        end
    end

    // Control register; deep wake restores power-on values
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl <= `CTRL_RESET;
        end else if (deep_wake) begin
            ctrl <= `CTRL_RESET;
        end else if (reg_write(bus, `ADDR_CTRL)) begin
            ctrl <= bus.wdata;
        end
    end

    // Clock source register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clk_cfg <= `CLK_RESET;
        end else if (deep_wake) begin
            clk_cfg <= `CLK_RESET;
        end else if (reg_write(bus, `ADDR_CLK)) begin
            clk_cfg <= {1'h0, bus.wdata[6:0]};
        end
    end

    // Recovery flag; a wake in the acknowledge cycle keeps it set
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            recovery_flag <= 1'h0;
        end else if (deep_wake) begin
            recovery_flag <= 1'h1;
        end else if (ack_write) begin
            recovery_flag <= 1'h0;
        end
    end

    // Pin control latch closes on deep entry, opens only on acknowledge
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            io_latch <= 1'h0;
        end else if (state == MODE_RUN && stop_req && ctrl[`CTRL_STOP_EN]
                     && select_mode(ctrl) == MODE_DEEP) begin
            io_latch <= 1'h1;
        end else if (ack_write && !in_deep) begin
            io_latch <= 1'h0;
        end
    end

    // Register readback, valid the cycle after the read strobe
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `ADDR_CTRL: rdata <= ctrl;
                `ADDR_CLK:  rdata <= clk_cfg;
                `ADDR_STAT: rdata <= {3'h0, io_latch, 2'(state), 1'h0, recovery_flag};
                default:    rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Reset and vector requests, one cycle each
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            illegal_reset <= 1'h0;
            reset_fetch   <= 1'h0;
            irq_fetch     <= 1'h0;
            por_reset     <= 1'h0;
        end else begin
            illegal_reset <= (state == MODE_RUN) && stop_req && !ctrl[`CTRL_STOP_EN];
            reset_fetch   <= (in_light && !pin_sync_n) || deep_wake;
            irq_fetch     <= in_light && pin_sync_n && light_irq;
            por_reset     <= deep_wake;
        end
    end

    // Debug command answers; memory access never happens while stopped
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dbg_mem_grant    <= 1'h0;
            dbg_stop_err     <= 1'h0;
            enter_background <= 1'h0;
        end else begin
            dbg_mem_grant    <= dbg_mem_cmd && (state == MODE_RUN);
            dbg_stop_err     <= dbg_mem_cmd && (state != MODE_RUN);
            enter_background <= bg_wake || (dbg_bg_cmd && state == MODE_RUN);
        end
    end

    assign clk_gate.bus_clk    = (state == MODE_RUN);
    assign clk_gate.cpu_clk    = (state == MODE_RUN);
    assign clk_gate.periph_clk = (state == MODE_RUN);
    assign clk_gate.debug_clk  = (state == MODE_RUN) ||
                                 (in_light && cap_ctrl[`CTRL_DBG_EN]);
    assign clk_gate.irc_keep   = in_light && cap_clk[`CLK_IRC_EN] && cap_clk[`CLK_IRC_STOP];
    assign clk_gate.external_oscillator_keep = in_light && cap_clk[`CLK_ERC_EN] && cap_clk[`CLK_ERC_STOP]
                                 && (!cap_clk[`CLK_HIGH_RANGE] || cap_ctrl[`CTRL_VD_EN]);

    assign power.regulator_full = (state == MODE_RUN) || (in_light &&
                                  (cap_ctrl[`CTRL_DBG_EN] ||
                                  (cap_ctrl[`CTRL_VD_EN] && cap_ctrl[`CTRL_VD_STOP_EN])));
    assign power.adc_run      = in_light && cap_ctrl[`CTRL_VD_EN] && cap_clk[`CLK_ADC_ASYNC];
    assign power.analog_comparator_run = in_light && (!cap_clk[`CLK_COMPARATOR_BG] || cap_ctrl[`CTRL_VD_EN]);
    assign power.core_off     = in_deep;
    assign power.state_retain = in_light || in_deep;
    assign power.io_latched   = io_latch;
    assign power.lvr_en       = ctrl[`CTRL_LVR_EN];
    assign power.high_trip    = ctrl[`CTRL_HIGH_TRIP];

    // idle pins follow port registers once latches open
    assign pin_by_port = io_latch ? 8'h00 : ~periph_pin_en;

endmodule
`default_nettype wire

// >>> stop_ctrl_monitor.sv
// Assertion checker beside the stop-mode controller ports
`timescale 1ns/100ps
`default_nettype none
`include "stop_ctrl_defines.svh"
module stop_ctrl_monitor
    import stop_ctrl_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rstn,
    input wire bus_req_t   bus,
    input wire logic       stop_req,
    input wire wake_src_t  wake_in,
    input wire logic       dbg_mem_cmd,
    input wire logic       dbg_bg_cmd,
    input wire logic [7:0] periph_pin_en,
    input wire logic [7:0] pin_by_port,
    input wire clk_gate_t  clk_gate,
    input wire power_t     power,
    input wire logic       illegal_reset,
    input wire logic       reset_fetch,
    input wire logic       irq_fetch,
    input wire logic       por_reset,
    input wire logic       enter_background,
    input wire logic       dbg_mem_grant,
    input wire logic       dbg_stop_err
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [7:0] ctl;

    // Control shadow; lags a deep wake by a cycle, no stop is asked then
    always_ff @(posedge mclk) begin
        if (!rstn || por_reset)
            ctl <= `CTRL_RESET;
        else if (bus.wr && bus.addr == `ADDR_CTRL)
            ctl <= bus.wdata;
    end

    // Stop request taken while running and enabled
    sequence s_go;
        stop_req && clk_gate.bus_clk && ctl[0];
    endsequence
    sequence s_light;
        !clk_gate.bus_clk && !power.io_latched;
    endsequence

    AST_ILLEGAL: assert property (stop_req && clk_gate.bus_clk && !ctl[0] |=> illegal_reset && clk_gate.bus_clk)
        else $error("stop entered while disabled");
    AST_HALT: assert property (s_go |=> !clk_gate.bus_clk && !clk_gate.cpu_clk && !clk_gate.periph_clk)
        else $error("clocks not halted in stop");
    AST_DEBUG: assert property (s_go ##0 ctl[1] |=> clk_gate.debug_clk && power.regulator_full && !power.io_latched)
        else $error("debug stop wrong");
    AST_REGUL: assert property (s_go ##0 (ctl[2] && ctl[3]) |=> power.regulator_full && !power.io_latched)
        else $error("regulator not kept");
    AST_SELECT: assert property (s_go |=> power.io_latched == (ctl[4] && !ctl[1] && !ctl[3]))
        else $error("wrong stop depth");
    AST_DEEP_WAKE: assert property (por_reset |-> reset_fetch && !irq_fetch && power.lvr_en && !power.high_trip)
        else $error("deep wake not like power-on");
    AST_DEEP_HOLD: assert property (!clk_gate.bus_clk && power.io_latched |=> !irq_fetch && !enter_background)
        else $error("deep stop left by interrupt");
    AST_LIGHT_WAKE: assert property (s_light ##0 (|wake_in) |-> ##[1:4] (irq_fetch || reset_fetch))
        else $error("light stop not woken");
    AST_MEM_ERR: assert property (dbg_mem_cmd && !clk_gate.bus_clk |=> dbg_stop_err && !dbg_mem_grant)
        else $error("memory command served in stop");
    AST_BG_WAKE: assert property (dbg_bg_cmd && !clk_gate.bus_clk && clk_gate.debug_clk |=> enter_background)
        else $error("background command ignored");
    AST_PINS: assert property (!power.io_latched |-> pin_by_port == ~periph_pin_en)
        else $error("pin ownership wrong");
endmodule
bind stop_mode_controller stop_ctrl_monitor i_stop_ctrl_monitor (.*);
`default_nettype wire

// >>> wake_partner.sv
// Wake sources and reset pin outside the controller
`timescale 1ns/100ps
`default_nettype none
module wake_partner
    import stop_ctrl_pkg::*;
(
    input wire logic       mclk,
    input wire logic       fire,
    input wire logic       use_pin,
    input wire wake_src_t  src,
    input wire logic [3:0] lag,
    input wire logic       awake,
    output wire wake_src_t wake_in,
    output wire logic      reset_pin_n
);
    logic [3:0] cnt = 4'h0;
    logic       armed = 1'b0;

    // wake held after a lag until the core runs
    always @(posedge mclk) begin
        if (fire) begin
            armed <= 1'b1;
            cnt <= lag;
        end else if (armed && cnt != 4'h0)
            cnt <= cnt - 4'h1;
        else if (awake)
            armed <= 1'b0;
    end
    assign wake_in = (armed && cnt == 4'h0 && !use_pin) ? src : 6'h00;
    assign reset_pin_n = !(armed && cnt == 4'h0 && use_pin);
endmodule
`default_nettype wire

// >>> stop_mode_controller_test.sv
// Self-checking bench of the stop-mode controller
`timescale 1ns/100ps
`default_nettype none
`include "stop_ctrl_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module stop_mode_controller_test
    import stop_ctrl_pkg::*;
;
    logic       mclk = 1'b0, rstn = 1'b0, stop_req = 1'b0, dbg_mem_cmd = 1'b0, dbg_bg_cmd = 1'b0;
    logic       fire = 1'b0, use_pin = 1'b0, rd_d = 1'b0, deep;
    bus_req_t   bus = '0;
    wake_src_t  src = '0;
    logic [3:0] lag = 4'h0;
    logic [7:0] periph_pin_en = 8'h00, c, ck;
    logic [7:0] cfg [5] = '{8'h13, 8'h1D, 8'h05, 8'h15, 8'h35};
    logic [7:0] rdata, pin_by_port, exp_rd, q_rd [$];
    logic [6:0] exp_ev, q_ev [$];
    wire        reset_pin_n;
    wake_src_t  wake_in;
    clk_gate_t  clk_gate;
    power_t     power;
    logic       illegal_reset, reset_fetch, irq_fetch, por_reset, enter_background, dbg_mem_grant, dbg_stop_err;
    int         miscompares = 0, num_checks = 0;
    wire [6:0]  ev = {illegal_reset, reset_fetch, irq_fetch, por_reset, enter_background, dbg_mem_grant, dbg_stop_err};

    stop_mode_controller i_stop_mode_controller (.*);
    wake_partner i_wake_partner (.mclk, .fire, .use_pin, .src, .lag, .awake(clk_gate.bus_clk), .wake_in, .reset_pin_n);

    // Clock, 100 ns period
    initial forever #50 mclk = ~mclk;

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk) bus <= {a, d, 1'b1, 1'b0};
        @(posedge mclk) bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        q_rd.push_back(e);
        @(posedge mclk) bus <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk) bus <= '0;
    endtask
    // One-cycle strobe: 0 stop, 1 memory command, 2 background command
    task automatic strobe(input int k, input logic [6:0] e);
        if (e != 7'h00)
            q_ev.push_back(e);
        @(posedge mclk) {stop_req, dbg_mem_cmd, dbg_bg_cmd} <= 3'b100 >> k;
        @(posedge mclk) {stop_req, dbg_mem_cmd, dbg_bg_cmd} <= 3'b000;
    endtask
    // Lag stays under the wait, so a missing wake shows as a mismatch
    task automatic wake(input logic p, input wake_src_t s, input logic up, input logic [6:0] e);
        if (e != 7'h00)
            q_ev.push_back(e);
        @(posedge mclk) begin
            use_pin <= p;
            src <= s;
            lag <= 4'($urandom_range(0, 5));
            fire <= 1'b1;
        end
        @(posedge mclk) fire <= 1'b0;
        repeat (12) @(negedge mclk);
        `CHK(clk_gate.bus_clk, up)
    endtask
    task automatic finish_test();
        // Notes left over mean an expected result never came
        `CHK(q_ev.size() + q_rd.size(), 0)
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Results taken mid-cycle against the oldest note
    // Note popped once, so a mismatch report cannot eat the next one
    always @(negedge mclk) begin
        if (rd_d) begin
            exp_rd = q_rd.pop_front();
            `CHK(rdata, exp_rd)
        end
        if (ev !== 7'h00) begin
            exp_ev = q_ev.pop_front();
            `CHK(ev, exp_ev)
        end
    end
    always @(posedge mclk) rd_d <= bus.rd;

    // Watchdog well beyond the sequence length
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        finish_test();
    end

    initial begin
        void'($urandom(32'hC087));
        periph_pin_en <= 8'($urandom);
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        rd(`ADDR_CTRL, 8'h44);
        rd(4'hF, 8'h00);
        `CHK(pin_by_port, ~periph_pin_en)
        strobe(0, 7'h40);
        strobe(1, 7'h02);
        for (int i = 0; i < 5; i++) begin
            c = cfg[i];
            ck = 8'($urandom) & 8'h7F;
            deep = c[4] && !c[1] && !c[3];
            wr(`ADDR_CLK, ck);
            rd(`ADDR_CLK, ck);
            wr(`ADDR_CTRL, c);
            strobe(0, 7'h00);
            @(negedge mclk);
            `CHK(clk_gate[5:3], 3'b000)
            `CHK(clk_gate.debug_clk, c[1])
            `CHK(power.regulator_full, c[1] || (c[2] && c[3]))
            `CHK(power.adc_run, !deep && c[2] && ck[5])
            `CHK(power.analog_comparator_run, !deep && (c[2] || !ck[6]))
            `CHK(clk_gate.irc_keep, !deep && ck[0] && ck[1])
            `CHK(clk_gate.external_oscillator_keep, !deep && ck[2] && ck[3] && (c[2] || !ck[4]))
            wr(`ADDR_CTRL, c ^ 8'h10);
            `CHK(power.io_latched, deep)
            `CHK(power.core_off, deep)
            `CHK(power.state_retain, 1'b1)
            rd(`ADDR_STAT, deep ? 8'h18 : 8'h04);
            strobe(1, 7'h01);
            if (i == 0) begin
                strobe(2, 7'h04);
                @(negedge mclk);
                `CHK(clk_gate.bus_clk, 1'b1)
                strobe(1, 7'h02);
            end else if (i == 1)
                wake(1'b0, 6'h01 << $urandom_range(0, 5), 1'b1, 7'h10);
            else if (i == 2)
                wake(1'b1, 6'h00, 1'b1, 7'h20);
            else begin
                if (i == 3)
                    wake(1'b0, 6'h1F, 1'b0, 7'h00);
                wake(i == 3, (i == 3) ? 6'h00 : 6'h20, 1'b1, 7'h28);
                `CHK(pin_by_port, 8'h00)
                rd(`ADDR_STAT, 8'h11);
                rd(`ADDR_CTRL, 8'h44);
                wr(`ADDR_STAT, 8'h02);
                rd(`ADDR_STAT, 8'h00);
                `CHK(pin_by_port, ~periph_pin_en)
            end
        end
        repeat (3) @(posedge mclk);
        finish_test();
    end
endmodule
`default_nettype wire
